/* hdc_drive_defines.vh */
// Constants for the haptic drive control register bank
`ifndef HDC_DRIVE_DEFINES_VH
`define HDC_DRIVE_DEFINES_VH

// ****************************************
// Register map
// ****************************************
`define HDC_ADDR_CFG_A      8'h1d
`define HDC_ADDR_CFG_B      8'h1e
`define HDC_CFG_A_RST       8'ha0
`define HDC_CFG_B_RST       8'h20
`define HDC_CFG_B_WMASK     8'hf1
`define HDC_RDATA_NONE      8'h00

// ****************************************
// Field positions, drive_config_a
// ****************************************
`define HDC_NG_HI           7
`define HDC_NG_LO           6
`define HDC_ERM_LOOP        5
`define HDC_SUP_OFF         4
`define HDC_FMT             3
`define HDC_RATE            2
`define HDC_INSEL           1
`define HDC_OPEN            0

// ****************************************
// Field positions, drive_config_b
// ****************************************
`define HDC_ZC_HI           7
`define HDC_ZC_LO           6
`define HDC_CAL_HI          5
`define HDC_CAL_LO          4
`define HDC_OTP_STAT        2
`define HDC_OTP_PROG        0

// ****************************************
// Modes and levels
// ****************************************
`define HDC_MODE_EXT_INPUT  3'h3
`define HDC_NG_2PCT         8'h05
`define HDC_NG_4PCT         8'h0a
`define HDC_NG_8PCT         8'h14
`define HDC_SIGN_FLIP       8'h80
`define HDC_PWM_HALF_DIV    6'h3f

// ****************************************
// Timing
// ****************************************
`define HDC_CLK_PERIOD_NS   100
`define HDC_OL_UNIT_NS      98460
`define HDC_OL_UNIT_CYC     (`HDC_OL_UNIT_NS / `HDC_CLK_PERIOD_NS)
`define HDC_ZC0_NS          100000
`define HDC_ZC1_NS          200000
`define HDC_ZC2_NS          300000
`define HDC_ZC3_NS          390000
`define HDC_ZC0_CYC         (`HDC_ZC0_NS / `HDC_CLK_PERIOD_NS)
`define HDC_ZC1_CYC         (`HDC_ZC1_NS / `HDC_CLK_PERIOD_NS)
`define HDC_ZC2_CYC         (`HDC_ZC2_NS / `HDC_CLK_PERIOD_NS)
`define HDC_ZC3_CYC         (`HDC_ZC3_NS / `HDC_CLK_PERIOD_NS)

`endif

/* hdc_open_period_timer.v */
// Open-loop resonant drive period timer
`timescale 1ns/10ps

module hdc_open_period_timer #(
  parameter UNIT_CYCLES = 984              // Cycles per period step
) (
  input  wire       ref_clk_i,             // System clock
  input  wire       rst_i,                 // Async reset, active high
  input  wire       run_i,                 // Timer enabled
  input  wire [6:0] period_i,              // Period in steps
  output reg        tick_o                 // One pulse per period
);

  // ****************************************
  // Counters
  // ****************************************
  reg [16:0] unit_cnt_r;                   // Counts cycles inside a step
  reg [6:0]  step_cnt_r;                   // Counts steps inside a period
  wire       unit_end;                     // Last cycle of a step
  wire       step_end;                     // Last step of a period

  assign unit_end = (unit_cnt_r == UNIT_CYCLES[16:0] - 17'h00001);
  assign step_end = (step_cnt_r == period_i - 7'h01);

  // Step and period counting; a zero period yields no ticks
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      unit_cnt_r <= 17'h00000;
      step_cnt_r <= 7'h00;
      tick_o     <= 1'b0;
    end else if (!run_i || (period_i == 7'h00)) begin
      // Held idle so a restart begins on a clean period
      unit_cnt_r <= 17'h00000;
      step_cnt_r <= 7'h00;
      tick_o     <= 1'b0;
    end else if (unit_end) begin
      unit_cnt_r <= 17'h00000;
      if (step_end) begin
        step_cnt_r <= 7'h00;
        tick_o     <= 1'b1;
      end else begin
        step_cnt_r <= step_cnt_r + 7'h01;
        tick_o     <= 1'b0;
      end
    end else begin
      unit_cnt_r <= unit_cnt_r + 17'h00001;
      tick_o     <= 1'b0;
    end
  end

endmodule // hdc_open_period_timer

/* hdc_drive_control_regs.v */
// Haptic drive control register bank with its decoded drive controls
//
// Function
// - Noise gate off, 2, 4 or 8 percent
// - Eccentric motor: bit 0 closed, 1 open loop
// - Closed-loop eccentric drive gets overdrive and braking
// - Supply compensation on unless disable bit set
// - Direct playback data signed at 0, unsigned 1
// - Resonant amplitude update once or twice per cycle
// - Mode 3 input pin: PWM or analog
// - Mode 3 amplitude scaled by duty or analog level, other modes pass it through
// - Open bit: fixed frequency except with analog input or eccentric motor, else auto-resonance
// - PWM open drive divides PWM frequency by 128
// - Other modes take frequency from period field
// - Open period is field times 984 cycles, 98.4 us at 10 MHz
`timescale 1ns/10ps
`include "hdc_drive_defines.vh"

module hdc_drive_control_regs #(
  parameter OL_UNIT_CYCLES = `HDC_OL_UNIT_CYC  // Cycles per open period step
) (
  input  wire        ref_clk_i,            // System clock, 10 MHz
  input  wire        rst_i,                // Async reset, active high
  input  wire [7:0]  reg_addr_i,           // Register address from I2C engine
  input  wire [7:0]  reg_wdata_i,          // Write data
  input  wire        reg_wr_i,             // Write strobe, one cycle
  input  wire        reg_rd_i,             // Read strobe, one cycle
  output reg  [7:0]  reg_rdata_o,          // Read data, valid after read strobe
  input  wire [2:0]  mode_i,               // Operating mode field
  input  wire        erm_select_i,         // High when eccentric motor fitted
  input  wire        input_trigger_pin_i,  // PWM input pin level
  input  wire [6:0]  open_drive_period_i,  // Open period field from its register
  input  wire [7:0]  pwm_duty_i,           // Measured PWM duty, 0..255
  input  wire [7:0]  analog_level_i,       // Measured analog level, 0..255
  input  wire [7:0]  wave_amp_i,           // Waveform amplitude from playback
  input  wire [7:0]  direct_host_playback_i, // Raw direct playback byte
  input  wire        otp_done_i,           // Pulse when OTP write completes
  output reg  [1:0]  noise_gate_level_o,   // Noise gate field
  output reg         rotary_motor_loop_select_o, // 1 open loop
  output reg         erm_boost_brake_o,    // Overdrive and braking enable
  output reg         supply_comp_en_o,     // Supply compensation active
  output reg         playback_signed_o,    // Direct playback data signed
  output reg  [7:0]  playback_level_o,     // Playback byte as offset binary
  output reg         resonant_update_rate_o, // 1 twice per cycle
  output reg         analog_input_o,       // Pin used as analog input
  output reg  [7:0]  drive_amp_o,          // Scaled drive amplitude
  output reg         open_drive_active_o,  // Fixed-frequency resonant drive
  output reg         commutate_o,          // Open drive polarity
  output reg  [11:0] zero_cross_cycles_o,  // Zero-cross window in cycles
  output reg  [1:0]  cal_time_sel_o,       // Auto-calibration duration field
  output reg         otp_program_start_o   // One pulse starts OTP write
);

  // ****************************************
  // Register storage
  // ****************************************
  reg  [7:0] cfg_a_r;                      // drive_config_a
  reg  [7:0] cfg_b_r;                      // drive_config_b, writable bits
  reg        otp_status_r;                 // Sticky programmed flag
  reg        otp_started_r;                // Program once per reset
  reg        pwm_prev_r;                   // Last pin sample for edges
  reg  [5:0] pwm_edge_cnt_r;               // Edges in a half period
  reg        pwm_comm_r;                   // PWM-derived polarity
  reg        timer_comm_r;                 // Timer-derived polarity
  reg  [7:0] drive_amp_nxt;                // Next scaled amplitude
  reg  [7:0] gated;                        // Gated scale source
  reg [15:0] product;                      // Amplitude product
  wire       pwm_rise;                     // PWM rising edge
  wire       ext_mode;                     // External input mode
  wire       pwm_open;                     // Open drive fed by PWM
  wire       open_ok;                      // Open drive permitted
  wire       timer_tick;                   // Period timer tick
  wire       prog_req;                     // Program bit written high

  // Gate a level to zero below the selected threshold
  function [7:0] ng_gate;
    input [7:0] level;
    input [1:0] sel;
    reg   [7:0] thr;
    begin
      thr = 8'h00;
      if (sel == 2'h1) begin
        thr = `HDC_NG_2PCT;
      end else if (sel == 2'h2) begin
        thr = `HDC_NG_4PCT;
      end else if (sel == 2'h3) begin
        thr = `HDC_NG_8PCT;
      end
      ng_gate = (level < thr) ? 8'h00 : level;
    end
  endfunction

  // Zero-cross window length in clock cycles
  function [11:0] zc_cycles;
    input [1:0]  sel;
    reg   [31:0] cyc;                      // Full-width count before the cut
    begin
      case (sel)
        2'h0:    cyc = `HDC_ZC0_CYC;
        2'h1:    cyc = `HDC_ZC1_CYC;
        2'h2:    cyc = `HDC_ZC2_CYC;
        default: cyc = `HDC_ZC3_CYC;
      endcase
      // All four windows fit in twelve bits
      zc_cycles = cyc[11:0];
    end
  endfunction

  assign ext_mode   = (mode_i == `HDC_MODE_EXT_INPUT);
  // Analog plus open drive is unsupported, so auto-resonance is kept
  assign open_ok    = cfg_a_r[`HDC_OPEN] && !(ext_mode && cfg_a_r[`HDC_INSEL]);
  assign pwm_open   = open_ok && ext_mode;
  assign pwm_rise   = input_trigger_pin_i && !pwm_prev_r;
  assign prog_req   = reg_wr_i && (reg_addr_i == `HDC_ADDR_CFG_B) &&
                      reg_wdata_i[`HDC_OTP_PROG];

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_a_r <= `HDC_CFG_A_RST;
      cfg_b_r <= `HDC_CFG_B_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `HDC_ADDR_CFG_A) begin
        cfg_a_r <= reg_wdata_i;
      end else if (reg_addr_i == `HDC_ADDR_CFG_B) begin
        // Reserved and status bits are not storable
        cfg_b_r <= reg_wdata_i & `HDC_CFG_B_WMASK;
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `HDC_ADDR_CFG_A) begin
        reg_rdata_o <= cfg_a_r;
      end else if (reg_addr_i == `HDC_ADDR_CFG_B) begin
        reg_rdata_o <= cfg_b_r | {5'h00, otp_status_r, 2'h0};
      end else begin
        // Unmapped addresses read as zero
        reg_rdata_o <= `HDC_RDATA_NONE;
      end
    end
  end

  // ****************************************
  // OTP programming
  // ****************************************
  // Done sets status even on the cycle a start is requested
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      otp_status_r        <= 1'b0;
      otp_started_r       <= 1'b0;
      otp_program_start_o <= 1'b0;
    end else begin
      if (otp_done_i) begin
        otp_status_r <= 1'b1;
      end
      // Fuses burn once: later requests are ignored until reset
      if (prog_req && !otp_started_r && !otp_status_r) begin
        otp_started_r       <= 1'b1;
        otp_program_start_o <= 1'b1;
      end else begin
        otp_program_start_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // PWM frequency recovery
  // ****************************************
  // Toggle every 64 edges gives one drive period per 128 input periods
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_prev_r     <= 1'b0;
      pwm_edge_cnt_r <= 6'h00;
      pwm_comm_r     <= 1'b0;
    end else begin
      pwm_prev_r <= input_trigger_pin_i;
      if (!pwm_open) begin
        pwm_edge_cnt_r <= 6'h00;
      end else if (pwm_rise) begin
        if (pwm_edge_cnt_r == `HDC_PWM_HALF_DIV) begin
          pwm_edge_cnt_r <= 6'h00;
          pwm_comm_r     <= !pwm_comm_r;
        end else begin
          pwm_edge_cnt_r <= pwm_edge_cnt_r + 6'h01;
        end
      end
    end
  end

  // ****************************************
  // Period-field frequency source
  // ****************************************
  // Half steps, so two polarity toggles make one full drive period;
  // an odd OL_UNIT_CYCLES loses its half cycle
  hdc_open_period_timer #(
    .UNIT_CYCLES (OL_UNIT_CYCLES / 2)
  ) u_period_timer (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .run_i       (open_ok && !ext_mode),
    .period_i    (open_drive_period_i),
    .tick_o      (timer_tick)
  );

  // Timer toggles polarity once per half drive period
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_comm_r <= 1'b0;
    end else if (timer_tick) begin
      timer_comm_r <= !timer_comm_r;
    end
  end

  // ****************************************
  // Amplitude scaling
  // ****************************************
  always @* begin
    gated   = ng_gate(cfg_a_r[`HDC_INSEL] ? analog_level_i : pwm_duty_i,
                      cfg_a_r[`HDC_NG_HI:`HDC_NG_LO]);
    product = wave_amp_i * gated;
    if (ext_mode) begin
      drive_amp_nxt = product[15:8];
    end else begin
      drive_amp_nxt = wave_amp_i;
    end
  end

  // ****************************************
  // Registered control outputs
  // ****************************************
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      noise_gate_level_o         <= 2'h0;
      rotary_motor_loop_select_o <= 1'b0;
      erm_boost_brake_o          <= 1'b0;
      supply_comp_en_o           <= 1'b0;
      playback_signed_o          <= 1'b0;
      playback_level_o           <= 8'h00;
      resonant_update_rate_o     <= 1'b0;
      analog_input_o             <= 1'b0;
      drive_amp_o                <= 8'h00;
      open_drive_active_o        <= 1'b0;
      commutate_o                <= 1'b0;
      zero_cross_cycles_o        <= 12'h000;
      cal_time_sel_o             <= 2'h0;
    end else begin
      noise_gate_level_o         <= cfg_a_r[`HDC_NG_HI:`HDC_NG_LO];
      rotary_motor_loop_select_o <= cfg_a_r[`HDC_ERM_LOOP];
      erm_boost_brake_o          <= erm_select_i && !cfg_a_r[`HDC_ERM_LOOP];
      supply_comp_en_o           <= !cfg_a_r[`HDC_SUP_OFF];
      playback_signed_o          <= !cfg_a_r[`HDC_FMT];
      // Signed bytes map to offset binary so both forms share one scale
      if (cfg_a_r[`HDC_FMT]) begin
        playback_level_o <= direct_host_playback_i;
      end else begin
        playback_level_o <= direct_host_playback_i ^ `HDC_SIGN_FLIP;
      end
      resonant_update_rate_o     <= cfg_a_r[`HDC_RATE];
      analog_input_o             <= ext_mode && cfg_a_r[`HDC_INSEL];
      drive_amp_o                <= drive_amp_nxt;
      open_drive_active_o        <= open_ok && !erm_select_i;
      commutate_o                <= pwm_open ? pwm_comm_r : timer_comm_r;
      zero_cross_cycles_o        <= zc_cycles(cfg_b_r[`HDC_ZC_HI:`HDC_ZC_LO]);
      cal_time_sel_o             <= cfg_b_r[`HDC_CAL_HI:`HDC_CAL_LO];
    end
  end

endmodule // hdc_drive_control_regs

/* hdc_drive_control_regs_assertions.sv */
// Port-level checks for the drive control register bank
`timescale 1ns/10ps
`include "hdc_drive_defines.vh"

module hdc_drive_control_regs_chk #(
  parameter OL_UNIT_CYCLES = 984           // Mirrors the bank, unused here
) (
  input wire       ref_clk_i,
  input wire       rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire [2:0] mode_i,
  input wire       erm_select_i,
  input wire [7:0] wave_amp_i,
  input wire [7:0] direct_host_playback_i,
  input wire [1:0] noise_gate_level_o,
  input wire       rotary_motor_loop_select_o,
  input wire       erm_boost_brake_o,
  input wire       supply_comp_en_o,
  input wire       playback_signed_o,
  input wire [7:0] playback_level_o,
  input wire       resonant_update_rate_o,
  input wire       analog_input_o,
  input wire [7:0] drive_amp_o,
  input wire       open_drive_active_o,
  input wire [1:0] cal_time_sel_o,
  input wire       otp_program_start_o
);
  // ****************
  // Helper state
  // ****************
  reg [1:0] live_r;                        // Edges since reset, saturates
  reg [7:0] w1_r;                          // Write data one edge old
  reg [7:0] w2_r;                          // Write data two edges old
  reg       prog_r;                        // Program request seen last edge
  // Outputs settle one edge after reset; the boost, sign and amp checks wait for live_r to reach three
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      live_r <= 2'h0;
      w1_r   <= 8'h00;
      w2_r   <= 8'h00;
      prog_r <= 1'b0;
    end else begin
      live_r <= (live_r == 2'h3) ? live_r : live_r + 2'h1;
      w1_r   <= reg_wdata_i;
      w2_r   <= w1_r;
      prog_r <= reg_wr_i && reg_addr_i == `HDC_ADDR_CFG_B && reg_wdata_i[0];
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr_a; reg_wr_i && reg_addr_i == `HDC_ADDR_CFG_A ##1 !reg_wr_i; endsequence
  sequence s_wr_b; reg_wr_i && reg_addr_i == `HDC_ADDR_CFG_B ##1 !reg_wr_i; endsequence
  property p_noise_gate; s_wr_a |=> noise_gate_level_o == w2_r[7:6]; endproperty
  a_noise_gate: assert property (p_noise_gate) else $error("gate level wrong");
  property p_loop_sel; s_wr_a |=> rotary_motor_loop_select_o == w2_r[5]; endproperty
  a_loop_sel: assert property (p_loop_sel) else $error("loop select wrong");
  property p_supply; s_wr_a |=> supply_comp_en_o == !w2_r[4]; endproperty
  a_supply: assert property (p_supply) else $error("supply comp wrong");
  property p_rate; s_wr_a |=> resonant_update_rate_o == w2_r[2]; endproperty
  a_rate: assert property (p_rate) else $error("update rate wrong");
  property p_cal; s_wr_b |=> cal_time_sel_o == w2_r[5:4]; endproperty
  a_cal: assert property (p_cal) else $error("cal select wrong");
  property p_boost; live_r == 2'h3 |-> erm_boost_brake_o ==
    ($past(erm_select_i) && !rotary_motor_loop_select_o); endproperty
  a_boost: assert property (p_boost) else $error("boost enable wrong");
  property p_sign; live_r == 2'h3 |-> playback_level_o ==
    ($past(direct_host_playback_i) ^ {playback_signed_o, 7'h00}); endproperty
  a_sign: assert property (p_sign) else $error("playback level wrong");
  property p_analog; analog_input_o |-> $past(mode_i) == `HDC_MODE_EXT_INPUT; endproperty
  a_analog: assert property (p_analog) else $error("analog outside mode");
  property p_amp; live_r == 2'h3 && $past(mode_i) != `HDC_MODE_EXT_INPUT
    |-> drive_amp_o == $past(wave_amp_i); endproperty
  a_amp: assert property (p_amp) else $error("amp not passed through");
  property p_open; open_drive_active_o |-> !$past(erm_select_i) && !analog_input_o; endproperty
  a_open: assert property (p_open) else $error("open drive wrong");
  property p_otp; otp_program_start_o |-> prog_r ##1 !otp_program_start_o [*8]; endproperty
  a_otp: assert property (p_otp) else $error("program pulse wrong");
endmodule // hdc_drive_control_regs_chk

bind hdc_drive_control_regs hdc_drive_control_regs_chk
  #(.OL_UNIT_CYCLES(OL_UNIT_CYCLES)) chk_u (.*);

/* hdc_pwm_source.sv */
// Behavioural PWM source standing at the input/trigger pin
`timescale 1ns/10ps

module hdc_pwm_source (
  input  wire       ref_clk_i,             // Bench clock
  input  wire       run_i,                 // Source active
  input  wire [7:0] half_cyc_i,            // Cycles per half period
  output reg        pwm_o                  // Level on the pin
);
  reg [7:0] cnt_r = 8'h00;                 // Cycles left in this half
  initial pwm_o = 1'b0;
  // Square wave, edges off the sampling edge; idle low between bursts
  always @(negedge ref_clk_i) begin
    if (!run_i) begin
      pwm_o <= 1'b0;
      cnt_r <= 8'h00;
    end else if (cnt_r == 8'h00) begin
      pwm_o <= !pwm_o;
      cnt_r <= half_cyc_i - 8'h01;
    end else begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // hdc_pwm_source

/* hdc_drive_control_regs_tb.sv */
// Self-checking bench for the drive control register bank
`timescale 1ns/10ps

module hdc_drive_control_regs_tb;
  typedef struct packed {
    logic [7:0] cfg; logic [2:0] mode; logic erm; logic [7:0] duty;
    logic [7:0] ana; logic [7:0] wave; logic [7:0] amp; logic anl; logic opn;
  } hdc_row_t;
  reg        clk, rst, wr, rd, erm, done, run, c0, pin_d;
  reg [7:0]  addr, wdata, duty, ana, wave, d;
  reg [2:0]  mode;
  reg [6:0]  olp;
  wire [7:0] rdata, amp;
  wire [1:0] ng, cal;
  wire [11:0] zc;
  wire       sup, anl, opn, com, otp, pin;
  int        error_cnt = 0, compares = 0, rises = 0, otp_cnt = 0, i, k, r[2];
  hdc_row_t  rows [0:8];
  logic [11:0] zc_tab [0:3] = '{12'h3e8, 12'h7d0, 12'hbb8, 12'hf3c};

  hdc_drive_control_regs #(.OL_UNIT_CYCLES(4)) dut_u (
    .ref_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .mode_i(mode),
    .erm_select_i(erm), .input_trigger_pin_i(pin), .open_drive_period_i(olp),
    .pwm_duty_i(duty),
    .analog_level_i(ana), .wave_amp_i(wave), .direct_host_playback_i(wave),
    .otp_done_i(done), .noise_gate_level_o(ng), .rotary_motor_loop_select_o(),
    .erm_boost_brake_o(), .supply_comp_en_o(sup), .playback_signed_o(),
    .playback_level_o(), .resonant_update_rate_o(), .analog_input_o(anl),
    .drive_amp_o(amp), .open_drive_active_o(opn), .commutate_o(com),
    .zero_cross_cycles_o(zc), .cal_time_sel_o(cal), .otp_program_start_o(otp));
  hdc_pwm_source src_u (.ref_clk_i(clk), .run_i(run), .half_cyc_i(8'h02), .pwm_o(pin));

  // ****************
  // Clock, monitors, tasks
  // ****************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Count pin rises and program pulses as the bank samples them
  always @(posedge clk) begin
    pin_d <= pin;
    if (pin && !pin_d) rises <= rises + 1;
    if (otp === 1'b1) otp_cnt <= otp_cnt + 1;
  end
  task automatic chk_val(input string n, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp=%h got=%h", n, e, g);
    end
  endtask
  // Negedges until commutate_o next changes, capped
  task automatic wait_com(output int n);
    c0 = com;
    n = 0;
    while (com === c0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Read data is registered, so it is taken one negedge after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk_val(n, {4'h0, e}, {4'h0, rdata});
  endtask
  task automatic rst_chk(input int n);
    rst = 1'b1;
    repeat (n) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    rd_chk(8'h1d, 8'ha0, "cfg_a");
    rd_chk(8'h1e, 8'h20, "cfg_b");
    rd_chk(8'h1f, 8'h00, "unmapped");
    chk_val("gate", 12'h2, {10'h0, ng});
    chk_val("zc", 12'h3e8, zc);
    chk_val("supply", 12'h1, {11'h0, sup});
    $display("reset test done");
  endtask
  task end_sim;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    {wr, rd, erm, done, run, addr, wdata, duty, ana, wave, mode, olp} = '0;
    rows = '{'{8'h00, 3'h3, 1'b0, 8'h03, 8'h00, 8'hff, 8'h02, 1'b0, 1'b0},
             '{8'h40, 3'h3, 1'b0, 8'h04, 8'h00, 8'hff, 8'h00, 1'b0, 1'b0},
             '{8'h40, 3'h3, 1'b0, 8'h05, 8'h00, 8'hff, 8'h04, 1'b0, 1'b0},
             '{8'h80, 3'h3, 1'b0, 8'h09, 8'h00, 8'hff, 8'h00, 1'b0, 1'b0},
             '{8'hc1, 3'h3, 1'b0, 8'h14, 8'h00, 8'hff, 8'h13, 1'b0, 1'b1},
             '{8'hc0, 3'h3, 1'b0, 8'h13, 8'h00, 8'hff, 8'h00, 1'b0, 1'b0},
             '{8'h03, 3'h3, 1'b0, 8'h00, 8'h80, 8'h80, 8'h40, 1'b1, 1'b0},
             '{8'h25, 3'h0, 1'b0, 8'h00, 8'h00, 8'h5a, 8'h5a, 1'b0, 1'b1},
             '{8'h09, 3'h0, 1'b1, 8'h00, 8'h00, 8'h11, 8'h11, 1'b0, 1'b0}};
    rst_chk(12);
    for (i = 0; i < 9; i++) begin
      {mode, erm, duty, ana, wave} = {rows[i].mode, rows[i].erm, rows[i].duty,
                                      rows[i].ana, rows[i].wave};
      wr_reg(8'h1d, rows[i].cfg);
      repeat (2) @(negedge clk);
      chk_val("amp", {4'h0, rows[i].amp}, {4'h0, amp});
      chk_val("analog", {11'h0, rows[i].anl}, {11'h0, anl});
      chk_val("open", {11'h0, rows[i].opn}, {11'h0, opn});
      $display("row %0d done", i);
    end
    for (i = 0; i < 4; i++) begin
      wr_reg(8'h1e, {i[1:0], 6'h2a});
      repeat (2) @(negedge clk);
      chk_val("zc", zc_tab[i], zc);
      rd_chk(8'h1e, {i[1:0], 6'h20}, "cfg_b");
    end
    $display("window test done");
    wr_reg(8'h1e, 8'hff);
    repeat (3) @(negedge clk);
    chk_val("starts", 12'h1, 12'(otp_cnt));
    chk_val("cal", 12'h3, {10'h0, cal});
    rd_chk(8'h1e, 8'hf1, "cfg_b");
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    rd_chk(8'h1e, 8'hf5, "cfg_b");
    wr_reg(8'h1e, 8'h01);
    repeat (3) @(negedge clk);
    chk_val("starts", 12'h1, 12'(otp_cnt));
    rd_chk(8'h1e, 8'h05, "cfg_b");
    $display("program test done");
    {mode, erm, run} = {3'h3, 1'b0, 1'b1};
    wr_reg(8'h1d, 8'h01);
    wait_com(k);
    r[0] = rises;
    wait_com(k);
    r[1] = rises;
    chk_val("pwm_rises", 12'd64, 12'(r[1] - r[0]));
    run = 1'b0;
    $display("divide test done");
    // Period 3 of 4-cycle steps: a toggle every 6 cycles
    {mode, olp} = {3'h0, 7'h03};
    repeat (3) wait_com(k);
    chk_val("half_period", 12'd6, 12'(k));
    $display("period test done");
    rst_chk(2);
    end_sim;
  end
  // Whole run is under a thousand cycles; this span means a hang
  initial begin
    #2000000;
    error_cnt++;
    $display("MISMATCH watchdog exp=done got=hang");
    end_sim;
  end
endmodule // hdc_drive_control_regs_tb
